// ===== logic/aim_pkg.sv
// Shared constants and types for the analog input parameter map
package aim_pkg;
	localparam int        MAP_LAST     = 153;
	localparam logic [7:0] W_SUMMARY   = 8'h00;
	localparam logic [7:0] W_HI_FLAGS  = 8'h11;
	localparam logic [7:0] W_LO_FLAGS  = 8'h12;
	localparam logic [7:0] W_LO_ACTIVE = 8'h2C;
	localparam logic [7:0] W_HI_ACTIVE = 8'h2D;
	localparam logic [7:0] W_POINTER   = 8'h2E;
	localparam logic [7:0] W_PT_ENABLE = 8'h2F;
	localparam logic [7:0] W_LO_EN     = 8'h35;
	localparam logic [7:0] W_HI_EN     = 8'h36;
	localparam logic [7:0] W_LIM_FIRST = 8'h37;
	localparam logic [7:0] W_LIM_LAST  = 8'h56;
	localparam logic [7:0] W_WR_LAST   = 8'h96;
	localparam logic [7:0] W_COUNTER   = 8'h97;
	localparam logic [7:0] W_ERRORS    = 8'h98;
	localparam logic [7:0] W_COMPARE   = 8'h99;
	localparam logic [7:0] W_MAP_END   = 8'h99;
	localparam logic [7:0] DEF_WR_PTR  = 8'h2F;
	localparam logic [7:0] BAD_PTR     = 8'hFF;
	localparam logic [15:0] PTR_RESET  = 16'h0000;
	localparam logic [15:0] PTR_MAXBCD = 16'h0153;
	localparam logic [15:0] LIM_BAD    = 16'h8000;
	localparam logic [15:0] CNT_WARN   = 16'h1388;
	localparam logic [15:0] CNT_LIFE   = 16'h2710;
	localparam logic [7:0] PAD_LIMIT   = 8'h7F;
	localparam int ERR_WARN = 1;
	localparam int ERR_LIFE = 2;
	localparam int ERR_SER  = 3;
	localparam int ERR_CAL  = 4;
	localparam int ERR_PAR  = 5;
	localparam int CLK_MHZ       = 40;
	localparam int HB_PERIOD_US  = 1000;
	localparam int HB_CYCLES     = HB_PERIOD_US * CLK_MHZ;
	typedef enum {ST_LOAD, ST_IDLE, ST_WR, ST_COMMIT, ST_RD, ST_STORE, ST_STORE_CNT} aim_state_t;
endpackage

// ===== logic/aim_link_if.sv
// Links between the map controller, alarm comparator and nonvolatile store
`timescale 1ns/1ps
interface aim_link_if;
	logic        nv_wr;
	logic [7:0]  nv_addr;
	logic [15:0] nv_wdata;
	logic [15:0] nv_rdata;
	logic [15:0] value;
	logic [15:0] low_lim;
	logic [15:0] high_lim;
	logic        hi_hit;
	logic        lo_hit;
	modport ctl (output nv_wr, nv_addr, nv_wdata, value, low_lim, high_lim,
		input nv_rdata, hi_hit, lo_hit);
	modport nvm (input nv_wr, nv_addr, nv_wdata, output nv_rdata);
	modport alm (input value, low_lim, high_lim, output hi_hit, lo_hit);
endinterface

// ===== logic/aim_alarm_cmp.sv
// Limit comparator for one conversion result
`timescale 1ns/1ps
module aim_alarm_cmp (
	aim_link_if.alm lk
);
	// Strict signed comparison against both limits
	always_comb begin
		lk.hi_hit = $signed(lk.value) > $signed(lk.high_lim);
		lk.lo_hit = $signed(lk.value) < $signed(lk.low_lim);
	end
endmodule

// ===== logic/aim_nv_store.sv
// Nonvolatile copy of the parameter map
`timescale 1ns/1ps
module aim_nv_store
	import aim_pkg::*;
(
	input wire logic sys_clk,
	aim_link_if.nvm  lk
);
	logic [15:0] nv [0:MAP_LAST];

	// Blank part holds zeros; contents survive the block reset
	initial begin
		for (int i = 0; i <= MAP_LAST; i++) begin
			nv[i] = 16'h0000;
		end
	end

	// One word written per cycle, read is combinational
	always_ff @(posedge sys_clk) begin
		if (lk.nv_wr) begin
			nv[lk.nv_addr] <= lk.nv_wdata;
		end
	end
	assign lk.nv_rdata = (lk.nv_addr <= W_MAP_END) ? nv[lk.nv_addr] : 16'h0000;
endmodule

// ===== logic/aim_param_map.sv
// Parameter map of the 16-point analog input unit
`timescale 1ns/1ps
//Contract
// - Out-of-limit conversion sets point alarm flag
// - Flags latch until controller reset bits
// - Word 53/54 enable low/high checks
// - Words 44/45 report active low/high checks
// - Limits in words 55..86, any value except 16'h8000
// - Power-up copies stored map to working
// - Store request copies whole map nonvolatile
// - Counter increments; compare must match again
// - Word 152 holds store error flags
// - Heartbeat frozen while storing
// - Map 154 words (0..153); pointer BCD, resets zero
// - Pointer selects transfer start location
// - One-word write loads pointer word
// - Reads start at new pointer
// - Pointer persists; restored from stored copy
// - Multi-word write first word temporary pointer
// - Reads past map end pad zeros
// - Any invalid word discards whole write
module aim_param_map
	import aim_pkg::*;
#(
	parameter int HB_CNT = HB_CYCLES
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// Block write instruction
	input  wire logic        wr_start,
	input  wire logic [7:0]  wr_count,
	input  wire logic        wr_valid,
	input  wire logic [15:0] wr_data,
	output logic             wr_ready,
	output logic             wr_error,
	// Block read instruction
	input  wire logic        rd_start,
	input  wire logic [7:0]  rd_count,
	output logic             start_ready,
	output logic             rd_valid,
	output logic [15:0]      rd_data,
	// Conversion results
	input  wire logic        conv_valid,
	input  wire logic [3:0]  conv_point,
	input  wire logic [15:0] conv_value,
	// Controller output word bits
	input  wire logic        store_req,
	input  wire logic [15:0] hi_alarm_clear,
	input  wire logic [15:0] lo_alarm_clear,
	// Unit fault inputs
	input  wire logic        serial_wr_disable,
	input  wire logic        cal_error,
	// Unit status
	output logic             unit_good,
	output logic             store_busy
);
	typedef struct packed {
		aim_state_t  st;
		logic [7:0]  idx;
		logic [7:0]  cnt;
		logic [7:0]  tptr;
		logic        bad;
		logic [15:0] ptr;
		logic [15:0] counter;
		logic [15:0] hi;
		logic [15:0] lo;
		logic        par_err;
		logic        wr_err;
		logic        req_q;
		logic        rd_v;
		logic [15:0] rd_d;
		logic [31:0] hb;
		logic        good;
	} aim_regs_t;

	aim_regs_t   r;
	aim_regs_t   next_r;
	logic [15:0] map   [W_PT_ENABLE:W_MAP_END];
	logic [15:0] stage [0:254];
	logic        map_we;
	logic [7:0]  map_wa;
	logic [15:0] map_wd;
	logic [7:0]  lim_a;
	aim_link_if  lk ();

	aim_alarm_cmp u_alarm (
		.lk (lk.alm)
	);
	aim_nv_store u_nv (
		.sys_clk (sys_clk),
		.lk      (lk.nvm)
	);

	// Unsigned BCD to binary; invalid digits give an out-of-map index
	function automatic logic [7:0] bcd2idx(input logic [15:0] b);
		logic [11:0] v;
		v = 12'h000;
		if (b[3:0] > 4'h9 || b[7:4] > 4'h9 || b[11:8] > 4'h9 || b[15:12] != 4'h0) begin
			return BAD_PTR;
		end
		v = 12'(b[11:8]) * 12'd100 + 12'(b[7:4]) * 12'd10 + 12'(b[3:0]);
		return (v > 12'(MAP_LAST)) ? BAD_PTR : v[7:0];
	endfunction

	// Writable locations and value ranges
	function automatic logic word_ok(input logic [7:0] a, input logic [15:0] d);
		logic in_area;
		in_area = (a >= W_PT_ENABLE && a <= W_WR_LAST) || a == W_COMPARE;
		// limits exclude the one unrepresentable value
		if (a >= W_LIM_FIRST && a <= W_LIM_LAST && d == LIM_BAD) begin
			return 1'b0;
		end
		return in_area;
	endfunction

	// Error word built from live state
	function automatic logic [15:0] err_word();
		logic [15:0] e;
		e = 16'h0000;
		e[ERR_WARN] = r.counter >= CNT_WARN;
		e[ERR_LIFE] = r.counter >= CNT_LIFE;
		e[ERR_SER]  = serial_wr_disable;
		e[ERR_CAL]  = cal_error;
		e[ERR_PAR]  = r.par_err;
		return e;
	endfunction

	// Map view as seen by reads and by the store copy
	function automatic logic [15:0] map_word(input logic [7:0] a);
		logic [15:0] pe;
		pe = map[W_PT_ENABLE];
		case (a)
			W_SUMMARY:   return r.hi | r.lo;
			W_HI_FLAGS:  return r.hi;
			W_LO_FLAGS:  return r.lo;
			// active = point enabled and check enabled
			W_LO_ACTIVE: return map[W_LO_EN] & pe;
			W_HI_ACTIVE: return map[W_HI_EN] & pe;
			W_POINTER:   return r.ptr;
			W_COUNTER:   return r.counter;
			W_ERRORS:    return err_word();
			default: begin
				if ((a >= W_PT_ENABLE && a <= W_WR_LAST) || a == W_COMPARE) begin
					return map[a];
				end
				return 16'h0000;
			end
		endcase
	endfunction

	// limit pair of the converting point
	assign lim_a       = W_LIM_FIRST + {3'b000, conv_point, 1'b0};
	assign lk.value    = conv_value;
	assign lk.low_lim  = map[lim_a];
	assign lk.high_lim = map[lim_a + 8'h01];

	// Handshakes and status
	assign wr_ready    = r.st == ST_WR;
	assign start_ready = r.st == ST_IDLE;
	assign store_busy  = r.st == ST_STORE || r.st == ST_STORE_CNT;
	assign wr_error    = r.wr_err;
	assign rd_valid    = r.rd_v;
	assign rd_data     = r.rd_d;
	assign unit_good   = r.good;

	// Next-state logic for the whole controller
	always_comb begin
		next_r      = r;
		map_we      = 1'b0;
		map_wa      = r.idx;
		map_wd      = lk.nv_rdata;
		lk.nv_wr    = 1'b0;
		lk.nv_addr  = r.idx;
		lk.nv_wdata = map_word(r.idx);
		next_r.req_q = store_req;
		next_r.rd_v  = 1'b0;
		next_r.rd_d  = 16'h0000;
		// clear by reset bits first, so a hit below wins
		next_r.hi = r.hi & ~hi_alarm_clear;
		next_r.lo = r.lo & ~lo_alarm_clear;
		if (conv_valid && map[W_PT_ENABLE][conv_point]) begin
			if (lk.hi_hit && map[W_HI_EN][conv_point]) begin
				next_r.hi[conv_point] = 1'b1;
			end
			if (lk.lo_hit && map[W_LO_EN][conv_point]) begin
				next_r.lo[conv_point] = 1'b1;
			end
		end
		// heartbeat toggles only outside a store
		if (!store_busy) begin
			if (r.hb >= 32'(HB_CNT - 1)) begin
				next_r.hb   = 32'h0;
				next_r.good = ~r.good;
			end else begin
				next_r.hb = r.hb + 32'h1;
			end
		end
		case (r.st)
			// copy stored map to working memory
			ST_LOAD: begin
				if (r.idx == W_POINTER) begin
					next_r.ptr     = lk.nv_rdata;
					next_r.par_err = bcd2idx(lk.nv_rdata) == BAD_PTR;
				end else if (r.idx == W_COUNTER) begin
					next_r.counter = lk.nv_rdata;
				end else begin
					map_we = (r.idx >= W_PT_ENABLE && r.idx <= W_WR_LAST) || r.idx == W_COMPARE;
				end
				next_r.idx = r.idx + 8'h01;
				if (r.idx == W_MAP_END) begin
					next_r.st  = ST_IDLE;
					next_r.idx = 8'h00;
				end
			end
			ST_IDLE: begin
				next_r.idx = 8'h00;
				// store only when compare matches counter
				if (store_req && !r.req_q && map[W_COMPARE] == r.counter) begin
					next_r.st = ST_STORE;
				end else if (wr_start && wr_count != 8'h00) begin
					next_r.st     = ST_WR;
					next_r.cnt    = wr_count;
					next_r.bad    = 1'b0;
					next_r.wr_err = 1'b0;
				end else if (rd_start && rd_count != 8'h00) begin
					next_r.st  = ST_RD;
					next_r.cnt = rd_count;
					next_r.tptr = bcd2idx(r.ptr);
				end
			end
			ST_WR: begin
				if (wr_valid) begin
					next_r.idx = r.idx + 8'h01;
					if (r.idx == 8'h00) begin
						// temporary pointer, zero means first writable
						next_r.tptr = (wr_data == 16'h0000) ? DEF_WR_PTR : bcd2idx(wr_data);
						if (wr_data != 16'h0000 && bcd2idx(wr_data) < DEF_WR_PTR) begin
							next_r.bad = r.cnt != 8'h01;
						end
						// pointer must be valid BCD in range
						if (bcd2idx(wr_data) == BAD_PTR) begin
							next_r.bad = 1'b1;
						end
					end else if (!word_ok(r.tptr + r.idx - 8'h01, wr_data)) begin
						// any bad word spoils the whole write
						next_r.bad = 1'b1;
					end
					if (r.idx + 8'h01 == r.cnt) begin
						next_r.idx = 8'h00;
						next_r.st  = ST_IDLE;
						// single word loads the pointer word
						if (r.cnt == 8'h01 && bcd2idx(wr_data) != BAD_PTR) begin
							next_r.ptr = wr_data;
						end else if (next_r.bad) begin
							next_r.wr_err = 1'b1;
						end else if (r.cnt != 8'h01) begin
							next_r.st = ST_COMMIT;
						end
						if (r.cnt == 8'h01) begin
							next_r.wr_err = bcd2idx(wr_data) == BAD_PTR;
						end
					end
				end
			end
			// All checked: commit staged words one per cycle
			ST_COMMIT: begin
				map_we     = 1'b1;
				map_wa     = r.tptr + r.idx;
				map_wd     = stage[r.idx];
				next_r.idx = r.idx + 8'h01;
				if (r.idx + 8'h02 >= r.cnt) begin
					next_r.st = ST_IDLE;
				end
			end
			// words past the map end read as zero
			ST_RD: begin
				next_r.rd_v = 1'b1;
				next_r.rd_d = (16'(r.tptr) + 16'(r.idx) <= 16'(W_MAP_END))
					? map_word(r.tptr + r.idx) : 16'h0000;
				next_r.idx = r.idx + 8'h01;
				if (r.idx + 8'h01 == r.cnt) begin
					next_r.st = ST_IDLE;
				end
			end
			ST_STORE: begin
				lk.nv_wr   = 1'b1;
				next_r.idx = r.idx + 8'h01;
				if (r.idx == W_MAP_END) begin
					next_r.st = ST_STORE_CNT;
				end
			end
			ST_STORE_CNT: begin
				lk.nv_wr       = 1'b1;
				lk.nv_addr     = W_COUNTER;
				lk.nv_wdata    = r.counter + 16'h0001;
				next_r.counter = r.counter + 16'h0001;
				next_r.st      = ST_IDLE;
				next_r.idx     = 8'h00;
			end
			default: next_r.st = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			r      <= '0;
			r.st   <= ST_LOAD;
			// pointer starts at zero until loaded
			r.ptr  <= PTR_RESET;
		end else begin
			r <= next_r;
		end
	end

	// Working map and write staging; arrays carry no reset
	always_ff @(posedge sys_clk) begin
		if (map_we) begin
			map[map_wa] <= map_wd;
		end
		if (r.st == ST_WR && wr_valid && r.idx != 8'h00) begin
			stage[r.idx - 8'h01] <= wr_data;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_hi_set;
		conv_valid && lk.hi_hit && map[W_PT_ENABLE][conv_point] && map[W_HI_EN][conv_point]
			|=> r.hi[$past(conv_point)];
	endproperty
	a_hi_set: assert property (p_hi_set) else $error("high flag not set");
	property p_latch;
		r.hi[0] && !hi_alarm_clear[0] |=> r.hi[0];
	endproperty
	a_latch: assert property (p_latch) else $error("high flag dropped");
	property p_no_check;
		conv_valid && !map[W_LO_EN][conv_point] && !r.lo[conv_point] && conv_point == 4'h0
			&& !lo_alarm_clear[0] |=> !r.lo[0];
	endproperty
	a_no_check: assert property (p_no_check) else $error("disabled check fired");
	property p_ptr_one;
		r.st == ST_WR && wr_valid && r.cnt == 8'h01 && bcd2idx(wr_data) != BAD_PTR
			|=> r.ptr == $past(wr_data) && r.st == ST_IDLE;
	endproperty
	a_ptr_one: assert property (p_ptr_one) else $error("pointer not loaded");
	property p_count;
		r.st == ST_STORE_CNT |=> r.counter == $past(r.counter) + 16'h0001;
	endproperty
	a_count: assert property (p_count) else $error("counter not bumped");
	property p_hb_hold;
		store_busy |=> $stable(unit_good);
	endproperty
	a_hb_hold: assert property (p_hb_hold) else $error("heartbeat moved in store");
	property p_pad;
		r.st == ST_RD && 16'(r.tptr) + 16'(r.idx) > 16'(W_MAP_END) |=> rd_valid && rd_data == 16'h0000;
	endproperty
	a_pad: assert property (p_pad) else $error("padding not zero");
	property p_store_len;
		r.st == ST_IDLE ##1 r.st == ST_STORE |-> ##154 r.st == ST_STORE_CNT;
	endproperty
	a_store_len: assert property (p_store_len) else $error("store length wrong");
	property p_reject;
		r.st == ST_WR && wr_valid && r.idx + 8'h01 == r.cnt && next_r.bad && r.cnt != 8'h01
			|=> r.st == ST_IDLE && wr_error;
	endproperty
	a_reject: assert property (p_reject) else $error("bad write committed");
	c_store: cover property (r.st == ST_STORE_CNT);
	c_commit: cover property (r.st == ST_COMMIT);
	c_pad: cover property (rd_valid && r.st == ST_RD && r.tptr > 8'h90);
endmodule

// ===== test/aim_cpu_model.sv
// Controller model issuing block transfers and store requests
`timescale 1ns/1ps
module aim_cpu_model (
	// Clock
	input  wire logic        sys_clk,
	// Block write side
	output logic             wr_start,
	output logic [7:0]       wr_count,
	output logic             wr_valid,
	output logic [15:0]      wr_data,
	input  wire logic        wr_ready,
	// Block read side
	output logic             rd_start,
	output logic [7:0]       rd_count,
	input  wire logic        start_ready,
	input  wire logic        rd_valid,
	input  wire logic [15:0] rd_data,
	// Output word bit 03
	output logic             store_req
);
	logic [15:0] buf_q[$];
	int          tmo;
	int          late;
	// Quiet lines at time zero
	initial begin
		wr_start = 1'b0;
		wr_count = 8'h00;
		wr_valid = 1'b0;
		wr_data = 16'h5A5A;
		rd_start = 1'b0;
		rd_count = 8'h00;
		store_req = 1'b0;
		late = 0;
	end
	// Bounded wait for the idle level
	task automatic wait_idle();
		tmo = 0;
		while (start_ready !== 1'b1 && tmo < 400) begin
			@(posedge sys_clk);
			#2;
			tmo++;
		end
		if (start_ready !== 1'b1) late++;
	endtask
	task automatic blk_write();
		int k;
		wait_idle();
		wr_count = 8'(buf_q.size());
		wr_start = 1'b1;
		@(posedge sys_clk);
		#2;
		wr_start = 1'b0;
		for (k = 0; k < buf_q.size(); k++) begin
			wr_valid = 1'b1;
			wr_data = buf_q[k];
			tmo = 0;
			while (wr_ready !== 1'b1 && tmo < 50) begin
				@(posedge sys_clk);
				#2;
				tmo++;
			end
			if (wr_ready !== 1'b1) late++;
			@(posedge sys_clk);
			#2;
		end
		wr_valid = 1'b0;
		// Released data must not look valid
		wr_data = ~wr_data;
		wait_idle();
	endtask
	task automatic blk_read(input int n);
		wait_idle();
		rd_count = 8'(n);
		rd_start = 1'b1;
		@(posedge sys_clk);
		#2;
		rd_start = 1'b0;
		buf_q = {};
		tmo = 0;
		while (buf_q.size() < n && tmo < 300) begin
			if (rd_valid === 1'b1) buf_q.push_back(rd_data);
			@(posedge sys_clk);
			#2;
			tmo++;
		end
		if (buf_q.size() < n) late++;
		wait_idle();
	endtask
	task automatic store_pulse();
		wait_idle();
		store_req = 1'b1;
		@(posedge sys_clk);
		#2;
		store_req = 1'b0;
	endtask
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the analog input parameter map
`timescale 1ns/1ps
module tb_top;
	import aim_pkg::*;
	logic        sys_clk, reset_n, wr_start, wr_valid, wr_ready, wr_error;
	logic        rd_start, start_ready, rd_valid, conv_valid, store_req;
	logic        serial_wr_disable, cal_error, unit_good, store_busy, hb;
	logic [7:0]  wr_count, rd_count;
	logic [3:0]  conv_point;
	logic [15:0] wr_data, rd_data, conv_value, hi_alarm_clear, lo_alarm_clear;
	logic [15:0] lo_en, hi_en, hf, lf, cnt, v;
	logic [15:0] lim[32];
	int          n_fail, n_checks, seed, k, p, moved;
	aim_cpu_model i_cpu (.sys_clk(sys_clk), .wr_start(wr_start), .wr_count(wr_count),
		.wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_start(rd_start),
		.rd_count(rd_count), .start_ready(start_ready), .rd_valid(rd_valid),
		.rd_data(rd_data), .store_req(store_req));
	// Short heartbeat keeps the run brief
	aim_param_map #(.HB_CNT(8)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.wr_start(wr_start), .wr_count(wr_count), .wr_valid(wr_valid), .wr_data(wr_data),
		.wr_ready(wr_ready), .wr_error(wr_error), .rd_start(rd_start), .rd_count(rd_count),
		.start_ready(start_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.conv_valid(conv_valid), .conv_point(conv_point), .conv_value(conv_value),
		.store_req(store_req), .hi_alarm_clear(hi_alarm_clear),
		.lo_alarm_clear(lo_alarm_clear), .serial_wr_disable(serial_wr_disable),
		.cal_error(cal_error), .unit_good(unit_good), .store_busy(store_busy));
	// Clock at 40 MHz
	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("Counts: %0d checks, %0d mismatches", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// One-word write moves the pointer
	task automatic wr1(input logic [15:0] w);
		i_cpu.buf_q = {w};
		i_cpu.blk_write();
	endtask
	// Signed strict compare for alarm limits
	function automatic logic above(input logic [15:0] a, input logic [15:0] b);
		return $signed(a) > $signed(b);
	endfunction
	// Hang guard, well past the expected run
	initial begin
		#500000;
		n_fail++;
		$display("Error at %0t: watchdog expired", $time);
		close_out();
	end
	// Main sequence
	initial begin
		seed = 32'hF60E11F4;
		n_fail = 0;
		n_checks = 0;
		reset_n = 1'b0;
		conv_valid = 1'b0;
		conv_point = 4'h0;
		conv_value = 16'h0000;
		hi_alarm_clear = 16'h0000;
		lo_alarm_clear = 16'h0000;
		serial_wr_disable = 1'($random(seed));
		cal_error = 1'($random(seed));
		repeat (6) @(posedge sys_clk);
		#2;
		reset_n = 1'b1;
		i_cpu.blk_read(47);
		check(16'(i_cpu.buf_q.size()), 16'd47);
		check(i_cpu.buf_q[46], PTR_RESET);
		wr1(16'h0046);
		i_cpu.blk_read(1);
		check(i_cpu.buf_q[0], 16'h0046);
		$display("Done: pointer");
		i_cpu.buf_q = {16'h0000, 16'h0000};
		i_cpu.blk_write();
		lo_en = 16'($random(seed));
		hi_en = 16'($random(seed));
		i_cpu.buf_q = {16'h0000, 16'hFFFF, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, lo_en, hi_en};
		for (k = 0; k < 32; k++) begin
			lim[k] = 16'($random(seed) % 7999);
			i_cpu.buf_q.push_back(lim[k]);
		end
		i_cpu.blk_write();
		check(16'(wr_error), 16'h0000);
		wr1(16'h0047);
		i_cpu.blk_read(40);
		check(i_cpu.buf_q[6], lo_en);
		check(i_cpu.buf_q[7], hi_en);
		for (k = 0; k < 32; k++) check(i_cpu.buf_q[8 + k], lim[k]);
		wr1(16'h0044);
		i_cpu.blk_read(2);
		check(i_cpu.buf_q[0], lo_en);
		check(i_cpu.buf_q[1], hi_en);
		$display("Done: config");
		// Values around each limit, equal included
		hf = 16'h0000;
		lf = 16'h0000;
		for (k = 0; k < 64; k++) begin
			p = $random(seed) & 15;
			v = lim[2 * p + (k & 1)] + 16'($random(seed) % 2);
			// Idle slots between conversions must not raise flags
			conv_valid = 1'($random(seed));
			if (conv_valid && hi_en[p] && above(v, lim[2 * p + 1])) hf[p] = 1'b1;
			if (conv_valid && lo_en[p] && above(lim[2 * p], v)) lf[p] = 1'b1;
			conv_point = 4'(p);
			conv_value = v;
			@(posedge sys_clk);
			#2;
		end
		conv_valid = 1'b0;
		conv_value = ~conv_value;
		wr1(16'h0017);
		i_cpu.blk_read(2);
		check(i_cpu.buf_q[0], hf);
		check(i_cpu.buf_q[1], lf);
		hi_alarm_clear = 16'($random(seed));
		lo_alarm_clear = 16'($random(seed));
		// Corner: a hit on point 0 in the clear cycle survives
		conv_valid = hi_en[0];
		conv_point = 4'h0;
		conv_value = 16'h7FFF;
		hf = (hf & ~hi_alarm_clear) | {15'h0000, hi_en[0]};
		lf = lf & ~lo_alarm_clear;
		@(posedge sys_clk);
		#2;
		conv_valid = 1'b0;
		hi_alarm_clear = 16'h0000;
		lo_alarm_clear = 16'h0000;
		i_cpu.blk_read(2);
		check(i_cpu.buf_q[0], hf);
		check(i_cpu.buf_q[1], lf);
		$display("Done: alarms");
		i_cpu.buf_q = {16'h0020, 16'h1111};
		i_cpu.blk_write();
		check(16'(wr_error), 16'h0001);
		i_cpu.buf_q = {16'h0055, 16'h1234, LIM_BAD};
		i_cpu.blk_write();
		check(16'(wr_error), 16'h0001);
		wr1(16'h0055);
		i_cpu.blk_read(1);
		check(i_cpu.buf_q[0], lim[0]);
		wr1(16'h0150);
		i_cpu.blk_read(6);
		check(i_cpu.buf_q[2], (16'(serial_wr_disable) << ERR_SER) | (16'(cal_error) << ERR_CAL));
		for (k = 3; k < 6; k++) check(i_cpu.buf_q[k], 16'h0000);
		$display("Done: refusals");
		wr1(16'h0151);
		i_cpu.blk_read(1);
		cnt = i_cpu.buf_q[0];
		i_cpu.buf_q = {16'h0153, cnt};
		i_cpu.blk_write();
		wr1(16'h0055);
		i_cpu.store_pulse();
		hb = unit_good;
		moved = 0;
		k = 0;
		while (store_busy === 1'b1 && k < 400) begin
			if (unit_good !== hb) moved = 1;
			@(posedge sys_clk);
			#2;
			k++;
		end
		check(16'(k), 16'd155);
		check(16'(moved), 16'h0000);
		// Heartbeat must move again within one period
		k = 0;
		while (unit_good === hb && k < 10) begin
			@(posedge sys_clk);
			#2;
			k++;
		end
		check(16'(unit_good !== hb), 16'h0001);
		wr1(16'h0151);
		i_cpu.blk_read(1);
		check(i_cpu.buf_q[0], cnt + 16'h0001);
		i_cpu.store_pulse();
		check(16'(store_busy), 16'h0000);
		$display("Done: store");
		reset_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		#2;
		reset_n = 1'b1;
		i_cpu.blk_read(1);
		check(i_cpu.buf_q[0], lim[0]);
		$display("Done: restore");
		check(16'(i_cpu.late), 16'h0000);
		close_out();
	end
endmodule
